// [rtl/spad_pkg.sv]
package spad_pkg;

    // Control/status space addresses.
    localparam logic [3:0]  CSS_PROG_STATUS   = 4'h0;
    localparam logic [3:0]  CSS_TURNAROUND    = 4'h2;
    localparam logic [3:0]  CSS_INTERFACE_ID  = 4'hf;

    // Field positions, reset values and guard-time constants.
    localparam int          PROG_EN_BIT       = 1;
    localparam int          GUARD_MSB         = 2;
    localparam logic [2:0]  GUARD_RESET       = 3'h0;
    localparam logic [2:0]  GUARD_ZERO_SEL    = 3'h7;
    localparam logic [7:0]  GUARD_MAX_BITS    = 8'h80;
    localparam logic [7:0]  IDLE_BASE_BITS    = 8'h02;
    localparam logic [15:0] POINTER_RESET     = 16'h0000;

    // Opcodes and opcode patterns.
    localparam logic [7:0]  OP_LOAD_IND       = 8'h20;
    localparam logic [7:0]  OP_LOAD_IND_INC   = 8'h24;
    localparam logic [7:0]  OP_STORE_IND      = 8'h60;
    localparam logic [7:0]  OP_STORE_IND_INC  = 8'h64;
    localparam logic [6:0]  OP_PTR_STORE_HI7  = 7'h34;
    localparam logic [3:0]  OP_CSS_READ_HI4   = 4'h8;
    localparam logic [3:0]  OP_CSS_WRITE_HI4  = 4'hc;
    localparam logic [7:0]  OP_KEY_SEND       = 8'he0;
    localparam int          OP_INC_BIT        = 2;
    localparam int          OP_IO_BIT         = 4;

    // Activation key and the index of its last byte.
    localparam logic [63:0] ACTIVATION_KEY    = 64'h1289ab45cdd888ff;
    localparam logic [2:0]  KEY_LAST_BYTE     = 3'h7;

    // Interface identification code; the value is arbitrary.
    localparam logic [7:0]  INTERFACE_ID_CODE = 8'h5a;

    typedef enum logic [6:0] {
        SPAD_IDLE    = 7'b0000001,
        SPAD_OPERAND = 7'b0000010,
        SPAD_KEY     = 7'b0000100,
        SPAD_REQ     = 7'b0001000,
        SPAD_BUSWAIT = 7'b0010000,
        SPAD_TURN    = 7'b0100000,
        SPAD_TXWAIT  = 7'b1000000
    } spad_state_t;

endpackage

// [rtl/spad_sync.sv]
`timescale 1ns/10ps
module spad_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // Two-stage synchroniser; only the second stage is visible.
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= d;
            sync_ff <= meta_ff;
        end
    end

    assign q = sync_ff;

endmodule

// [rtl/spad_decoder.sv]
// Summary of operation
// RL1: Opcode 0x20 loads data space at the pointer and transmits it; pointer kept.
// RL2: Opcode 0x24 does the same load and then increments the pointer by one.
// RL3: Opcode 0x60 writes the next received byte to data space at the pointer.
// RL4: A store variant increments the pointer after writing the byte.
// RL5: Opcode 0x64 is decoded as that post-increment store.
// RL6: Opcode 0110100a stores the next byte into pointer byte a.
// RL7: Opcode 0aa1aaaa reads I/O space at the 6-bit address and transmits it.
// RL8: Opcode 1aa1aaaa writes the next byte to I/O space at the 6-bit address.
// RL9: Opcode 1000aaaa reads control/status register aaaa and transmits it.
// RL10: Opcode 1100aaaa writes the next byte to control/status register aaaa.
// RL11: Opcode 0xe0 is followed by exactly eight key bytes collected by the device.
// RL12: Programming is off after reset; enabled only if the key equals 0x1289ab45cdd888ff.
// RL13: Programmer polls the status enable bit before using the memory controller.
// RL14: Writing zero to the enable bit disables programming.
// RL15: Control/status registers are reachable only by the two control/status instructions.
// RL16: Status at 0x0, enable in bit 1; turnaround at 0x2, guard bits 2:0; id at 0xf.
// RL17: The identification register returns a fixed 8-bit code.
// RL18: Guard codes 0..7 give 128,64,32,16,8,4,2,0 extra idle bits.
// RL19: Receive-to-transmit turnaround waits guard time plus two idle bits.
// RL20: No extra idle bits from transmit back to receive.
// RL21: The guard field resets to the 128-bit encoding.
// RL22: Programmer should set the shortest safe guard time.
// RL23: Read instructions get their operand from the device; writes from the programmer.
// RL24: Parity, frame, break or collision aborts to error; only a break leaves it.
`timescale 1ns/10ps
module spad_decoder (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        link_clk,
    input  wire logic        phy_init,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_break,
    input  wire logic        rx_error,
    input  wire logic        tx_done,
    output logic             tx_valid,
    output logic [7:0]       tx_data,
    output logic             phy_transmit,
    output logic             link_error,
    output logic             bus_req,
    output logic             bus_we,
    output logic             bus_io,
    output logic [15:0]      bus_addr,
    output logic [7:0]       bus_wdata,
    input  wire logic        bus_ack,
    input  wire logic [7:0]  bus_rdata,
    output logic             programming_enabled
);

    // Link-domain state.
    spad_pkg::spad_state_t state_ff;
    spad_pkg::spad_state_t nxt_state;
    logic [7:0]  op_ff;
    logic [15:0] address_pointer_ff;
    logic [7:0]  data_ff;
    logic [63:0] key_ff;
    logic [2:0]  key_cnt_ff;
    logic [2:0]  guard_time_select_ff;
    logic        prog_en_ff;
    logic [7:0]  idle_cnt_ff;
    logic        req_tgl_ff;
    logic        req_we_ff;
    logic        req_io_ff;
    logic [15:0] req_addr_ff;
    logic        tx_valid_ff;
    logic        phy_tx_ff;
    logic        err_ff;

    // System-domain state.
    logic        req_seen_ff;
    logic        ack_tgl_ff;
    logic        bus_req_ff;
    logic        bus_we_ff;
    logic        bus_io_ff;
    logic [15:0] bus_addr_ff;
    logic [7:0]  bus_wdata_ff;
    logic [7:0]  rd_hold_ff;

    logic        link_rst_sync;
    logic        ack_tgl_sync;
    logic        req_tgl_sync;
    logic        prog_en_sync;

    spad_sync #(.WIDTH(1)) u_rst_sync (.clk(link_clk), .reset_n(1'b1), .d(reset_n), .q(link_rst_sync));
    spad_sync #(.WIDTH(1)) u_ack_sync (.clk(link_clk), .reset_n(link_rst_sync), .d(ack_tgl_ff), .q(ack_tgl_sync));
    spad_sync #(.WIDTH(1)) u_req_sync (.clk(clk), .reset_n(reset_n), .d(req_tgl_ff), .q(req_tgl_sync));
    spad_sync #(.WIDTH(1)) u_en_sync (.clk(clk), .reset_n(reset_n), .d(prog_en_ff), .q(prog_en_sync));

    // The access layer is also reset whenever the physical layer initialises.
    wire link_rst = !link_rst_sync || phy_init;

    // Returns the extra idle bits for a guard code, halving from 128 down to 2, then 0.
    function automatic logic [7:0] guard_bits(input logic [2:0] sel);
        return (sel == spad_pkg::GUARD_ZERO_SEL) ? 8'h00 : (spad_pkg::GUARD_MAX_BITS >> sel);
    endfunction

    // Opcode decode on the freshly received byte.
    wire [7:0] op_in         = rx_data;
    wire       dec_load      = (op_in == spad_pkg::OP_LOAD_IND) || (op_in == spad_pkg::OP_LOAD_IND_INC); // [RL1] [RL2]
    wire       dec_store     = (op_in == spad_pkg::OP_STORE_IND) ||
                               (op_in == spad_pkg::OP_STORE_IND_INC);                // [RL3] [RL4] [RL5]
    wire       dec_ptr       = (op_in[7:1] == spad_pkg::OP_PTR_STORE_HI7);           // [RL6]
    wire       dec_io_rd     = !op_in[7] && op_in[spad_pkg::OP_IO_BIT];              // [RL7]
    wire       dec_io_wr     = op_in[7] && op_in[spad_pkg::OP_IO_BIT];               // [RL8]
    wire       dec_css_rd    = (op_in[7:4] == spad_pkg::OP_CSS_READ_HI4);            // [RL9]
    wire       dec_css_wr    = (op_in[7:4] == spad_pkg::OP_CSS_WRITE_HI4);           // [RL10]
    wire       dec_key       = (op_in == spad_pkg::OP_KEY_SEND);                     // [RL11]
    wire       dec_write     = dec_store || dec_ptr || dec_io_wr || dec_css_wr;
    wire [5:0] dec_io_addr   = {op_in[6:5], op_in[3:0]};

    // Decode of the held opcode while its operand or response is handled.
    wire       held_ptr      = (op_ff[7:1] == spad_pkg::OP_PTR_STORE_HI7);
    wire       held_css_wr   = (op_ff[7:4] == spad_pkg::OP_CSS_WRITE_HI4);
    wire       held_inc      = op_ff[spad_pkg::OP_INC_BIT] && !op_ff[spad_pkg::OP_IO_BIT] && !op_ff[7];
    wire [3:0] css_addr      = op_ff[3:0];

    // Control/status space read mux, indexed by the low four bits of every received opcode; only a control/status read transmits it.   [RL15]
    wire [7:0] css_rdata     = (op_in[3:0] == spad_pkg::CSS_PROG_STATUS)  ? {6'h00, prog_en_ff, 1'b0} :
                               (op_in[3:0] == spad_pkg::CSS_TURNAROUND)   ? {5'h00, guard_time_select_ff} :
                               (op_in[3:0] == spad_pkg::CSS_INTERFACE_ID) ? spad_pkg::INTERFACE_ID_CODE :
                               8'h00;                                                // [RL16] [RL17]

    wire       exception     = rx_error || rx_break;                                 // [RL24]
    wire       bus_idle      = (ack_tgl_sync == req_tgl_ff);
    wire       key_match     = ({key_ff[55:0], rx_data} == spad_pkg::ACTIVATION_KEY);
    wire [7:0] turn_bits     = guard_bits(guard_time_select_ff) + spad_pkg::IDLE_BASE_BITS; // [RL18] [RL19]

    // Next-state logic of the access layer.
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            spad_pkg::SPAD_IDLE:
                if (rx_valid && dec_key)
                    nxt_state = spad_pkg::SPAD_KEY;
                else if (rx_valid && dec_write)
                    nxt_state = spad_pkg::SPAD_OPERAND;
                else if (rx_valid && dec_css_rd)
                    nxt_state = spad_pkg::SPAD_TURN;
                else if (rx_valid && (dec_load || dec_io_rd))
                    nxt_state = spad_pkg::SPAD_REQ;
            spad_pkg::SPAD_OPERAND:
                if (rx_valid)
                    nxt_state = (held_ptr || held_css_wr) ? spad_pkg::SPAD_IDLE : spad_pkg::SPAD_REQ;
            spad_pkg::SPAD_KEY:
                if (rx_valid && key_cnt_ff == spad_pkg::KEY_LAST_BYTE)
                    nxt_state = spad_pkg::SPAD_IDLE;
            spad_pkg::SPAD_REQ:
                if (bus_idle)
                    nxt_state = spad_pkg::SPAD_BUSWAIT;
            spad_pkg::SPAD_BUSWAIT:
                if (bus_idle)
                    nxt_state = req_we_ff ? spad_pkg::SPAD_IDLE : spad_pkg::SPAD_TURN;
            spad_pkg::SPAD_TURN:
                if (idle_cnt_ff == 8'h01)
                    nxt_state = spad_pkg::SPAD_TXWAIT;
            spad_pkg::SPAD_TXWAIT:
                if (tx_done)
                    nxt_state = spad_pkg::SPAD_IDLE;                                 // [RL20]
            default:
                nxt_state = spad_pkg::SPAD_IDLE;
        endcase
    end

    // State register with error trap.
    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            state_ff <= spad_pkg::SPAD_IDLE;
            err_ff   <= 1'b0;
        end
        else if (err_ff)
        begin
            err_ff   <= !rx_break;                                                   // [RL24]
            state_ff <= spad_pkg::SPAD_IDLE;
        end
        else if (exception)
        begin
            err_ff   <= 1'b1;                                                        // [RL24]
            state_ff <= spad_pkg::SPAD_IDLE;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    wire run        = !err_ff && !exception;
    wire in_idle    = (state_ff == spad_pkg::SPAD_IDLE);
    wire in_operand = (state_ff == spad_pkg::SPAD_OPERAND);
    wire in_key     = (state_ff == spad_pkg::SPAD_KEY);
    wire in_req     = (state_ff == spad_pkg::SPAD_REQ);
    wire in_buswait = (state_ff == spad_pkg::SPAD_BUSWAIT);
    wire in_turn    = (state_ff == spad_pkg::SPAD_TURN);
    wire bus_done   = in_buswait && bus_idle;

    // Opcode, operand and read data.
    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            op_ff   <= 8'h00;
            data_ff <= 8'h00;
        end
        else if (run && in_idle && rx_valid)
        begin
            op_ff   <= rx_data;
            data_ff <= css_rdata;                                                    // [RL9] [RL23]
        end
        else if (run && in_operand && rx_valid)
            data_ff <= rx_data;
        else if (run && bus_done && !req_we_ff)
            data_ff <= rd_hold_ff;                                                   // [RL1] [RL7] [RL23]
    end

    // Address pointer: byte stores and post-increments.
    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            address_pointer_ff <= spad_pkg::POINTER_RESET;
        end
        else if (run && in_operand && rx_valid && held_ptr)
        begin
            if (op_ff[0])
                address_pointer_ff[15:8] <= rx_data;                                 // [RL6]
            else
                address_pointer_ff[7:0] <= rx_data;                                  // [RL6]
        end
        else if (run && bus_done && held_inc)
            address_pointer_ff <= address_pointer_ff + 16'h0001;                     // [RL2] [RL4] [RL5]
    end

    // Key collection and programming enable.
    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            key_ff     <= 64'h0;
            key_cnt_ff <= 3'h0;
            prog_en_ff <= 1'b0;                                                      // [RL12]
        end
        else if (run && in_key && rx_valid)
        begin
            key_ff     <= {key_ff[55:0], rx_data};                                   // [RL11]
            key_cnt_ff <= key_cnt_ff + 3'h1;
            if (key_cnt_ff == spad_pkg::KEY_LAST_BYTE && key_match)
                prog_en_ff <= 1'b1;                                                  // [RL12]
        end
        else if (run && in_operand && rx_valid && held_css_wr && css_addr == spad_pkg::CSS_PROG_STATUS)
            prog_en_ff <= prog_en_ff && rx_data[spad_pkg::PROG_EN_BIT];              // [RL14]
        else if (!in_key)
            key_cnt_ff <= 3'h0;
    end

    // Guard-time selection.
    always_ff @(posedge link_clk)
    begin
        if (link_rst)
            guard_time_select_ff <= spad_pkg::GUARD_RESET;                           // [RL21]
        else if (run && in_operand && rx_valid && held_css_wr && css_addr == spad_pkg::CSS_TURNAROUND)
            guard_time_select_ff <= rx_data[spad_pkg::GUARD_MSB:0];                  // [RL10] [RL16]
    end

    // Turnaround idle counter and transmit handshake to the physical layer.
    always_ff @(posedge link_clk)
    begin
        if (link_rst || !run)
        begin
            idle_cnt_ff <= 8'h00;
            tx_valid_ff <= 1'b0;
            phy_tx_ff   <= 1'b0;
        end
        else
        begin
            tx_valid_ff <= in_turn && (idle_cnt_ff == 8'h01);
            if (nxt_state == spad_pkg::SPAD_TURN && !in_turn)
            begin
                idle_cnt_ff <= turn_bits;                                            // [RL19]
                phy_tx_ff   <= 1'b1;
            end
            else if (in_turn)
                idle_cnt_ff <= idle_cnt_ff - 8'h01;
            else if (nxt_state == spad_pkg::SPAD_IDLE)
                phy_tx_ff   <= 1'b0;                                                 // [RL20]
        end
    end

    // Bus request launch; fields stay put until the acknowledge toggle returns.
    always_ff @(posedge link_clk)
    begin
        if (link_rst)
        begin
            req_tgl_ff  <= 1'b0;
            req_we_ff   <= 1'b0;
            req_io_ff   <= 1'b0;
            req_addr_ff <= 16'h0000;
        end
        else if (run && in_idle && rx_valid && (dec_load || dec_io_rd || dec_store || dec_io_wr))
        begin
            req_we_ff   <= dec_store || dec_io_wr;                                   // [RL3] [RL8]
            req_io_ff   <= op_in[spad_pkg::OP_IO_BIT];
            req_addr_ff <= op_in[spad_pkg::OP_IO_BIT] ? {10'h000, dec_io_addr} : address_pointer_ff;
        end
        else if (run && in_req && bus_idle)
        begin
            req_tgl_ff  <= !req_tgl_ff;
            if (!req_io_ff)
                req_addr_ff <= address_pointer_ff;
        end
    end

    // System-side bus master.
    wire req_new = (req_tgl_sync != req_seen_ff);

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            req_seen_ff  <= 1'b0;
            ack_tgl_ff   <= 1'b0;
            bus_req_ff   <= 1'b0;
            bus_we_ff    <= 1'b0;
            bus_io_ff    <= 1'b0;
            bus_addr_ff  <= 16'h0000;
            bus_wdata_ff <= 8'h00;
            rd_hold_ff   <= 8'h00;
        end
        else if (bus_req_ff && bus_ack)
        begin
            bus_req_ff <= 1'b0;
            rd_hold_ff <= bus_rdata;
            ack_tgl_ff <= req_seen_ff;
        end
        else if (req_new && !bus_req_ff)
        begin
            req_seen_ff  <= req_tgl_sync;
            bus_req_ff   <= 1'b1;
            bus_we_ff    <= req_we_ff;
            bus_io_ff    <= req_io_ff;
            bus_addr_ff  <= req_addr_ff;
            bus_wdata_ff <= data_ff;
        end
    end

    assign tx_valid            = tx_valid_ff;
    assign tx_data             = data_ff;
    assign phy_transmit        = phy_tx_ff;
    assign link_error          = err_ff;
    assign bus_req             = bus_req_ff;
    assign bus_we              = bus_we_ff;
    assign bus_io              = bus_io_ff;
    assign bus_addr            = bus_addr_ff;
    assign bus_wdata           = bus_wdata_ff;
    assign programming_enabled = prog_en_sync;

endmodule

// [verif/spad_monitor.sv]
`timescale 1ns/10ps
module spad_monitor (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        link_clk,
    input wire logic        phy_init,
    input wire logic        rx_break,
    input wire logic        rx_error,
    input wire logic        tx_done,
    input wire logic        tx_valid,
    input wire logic        phy_transmit,
    input wire logic        link_error,
    input wire logic        bus_req,
    input wire logic        bus_ack,
    input wire logic        bus_io,
    input wire logic        bus_we,
    input wire logic [15:0] bus_addr,
    input wire logic [7:0]  bus_wdata
);
    a_bus_hold: assert property (@(posedge clk) disable iff (!reset_n)
        bus_req && !bus_ack |=> bus_req && $stable(bus_addr) && $stable(bus_we) && $stable(bus_wdata))
        else $error("bus request changed before ack");
    a_io_addr: assert property (@(posedge clk) disable iff (!reset_n)
        bus_req && bus_io |-> bus_addr[15:6] == 10'h000) else $error("io address wider than six bits");
    a_tx_pulse: assert property (@(posedge link_clk) disable iff (!reset_n || phy_init)
        tx_valid |=> !tx_valid) else $error("tx_valid longer than one cycle");
    a_tx_dir: assert property (@(posedge link_clk) disable iff (!reset_n || phy_init)
        tx_valid |-> phy_transmit) else $error("send started in receive direction");
    a_min_idle: assert property (@(posedge link_clk) disable iff (!reset_n || phy_init)
        $rose(phy_transmit) |-> !tx_valid [*2]) else $error("turnaround shorter than two idle bits");
    a_back_rx: assert property (@(posedge link_clk) disable iff (!reset_n || phy_init)
        phy_transmit && tx_done |=> !phy_transmit) else $error("receive direction not resumed at once");
    a_err_enter: assert property (@(posedge link_clk) disable iff (!reset_n || phy_init)
        rx_error |=> link_error) else $error("fault did not enter error state");
    a_err_stay: assert property (@(posedge link_clk) disable iff (!reset_n || phy_init)
        link_error && !rx_break |=> link_error) else $error("error state left without break");
    a_err_leave: assert property (@(posedge link_clk) disable iff (!reset_n || phy_init)
        link_error && rx_break |=> !link_error) else $error("break did not clear error state");
    c_read: cover property (@(posedge link_clk) tx_valid);
    c_error: cover property (@(posedge link_clk) $rose(link_error));
    c_write: cover property (@(posedge clk) bus_req && bus_we && bus_ack);
endmodule

bind spad_decoder spad_monitor mon (.clk(clk), .reset_n(reset_n), .link_clk(link_clk), .phy_init(phy_init),
    .rx_break(rx_break), .rx_error(rx_error), .tx_done(tx_done), .tx_valid(tx_valid), .phy_transmit(phy_transmit),
    .link_error(link_error), .bus_req(bus_req), .bus_ack(bus_ack), .bus_io(bus_io), .bus_we(bus_we),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata));

// [verif/spad_prog_model.sv]
`timescale 1ns/10ps
module spad_prog_model (
    input  wire logic       link_clk,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_break,
    output logic            rx_error,
    output logic            tx_done
);
    initial
    begin
        {rx_valid, rx_break, rx_error, tx_done} = 4'h0;
        rx_data = 8'h00;
    end

    // Kind 0 is a byte, 1 a break, 2 a fault; idle bits separate frames.
    task automatic pulse(input logic [1:0] kind, input logic [7:0] v);
        repeat (2) @(negedge link_clk);
        rx_valid = kind == 2'h0;
        rx_break = kind == 2'h1;
        rx_error = kind == 2'h2;
        rx_data = v;
        @(negedge link_clk);
        {rx_valid, rx_break, rx_error} = 3'h0;
        rx_data = ~v;
    endtask

    // Counts link cycles until the device starts sending, then plays a full frame.
    task automatic recv(output logic [7:0] v, output int n);
        n = 0;
        v = 8'h00;
        while (n < 400 && tx_valid !== 1'b1)
        begin
            @(negedge link_clk);
            n++;
        end
        v = tx_data;
        repeat (11) @(negedge link_clk);
        tx_done = n < 400;
        @(negedge link_clk);
        tx_done = 1'b0;
    endtask
endmodule

// [verif/serial_prog_access_decoder_tb.sv]
`timescale 1ns/10ps
module serial_prog_access_decoder_tb;
    typedef struct packed {logic [7:0] op; logic [7:0] d; logic rd; logic [7:0] exp;} spad_row_t;
    localparam logic [63:0] act_key = 64'h1289ab45cdd888ff;
    logic        clk, link_clk, reset_n, phy_init, rx_valid, rx_break, rx_error, tx_done, tx_valid;
    logic        phy_transmit, link_error, bus_req, bus_we, bus_io, bus_ack, programming_enabled;
    logic [7:0]  rx_data, tx_data, bus_wdata, bus_rdata, b;
    logic [15:0] bus_addr;
    logic [7:0]  mem [0:255];
    int          err_count, checks_done, n;
    wire  [7:0]  idx = {bus_io, bus_addr[6:0]};
    spad_row_t   rows [18] = '{
        '{8'hc2, 8'h07, 1'b0, 8'h00},
        '{8'h82, 8'h00, 1'b1, 8'h07},
        '{8'h8f, 8'h00, 1'b1, spad_pkg::INTERFACE_ID_CODE},
        '{8'h81, 8'h00, 1'b1, 8'h00},
        '{8'h68, 8'h10, 1'b0, 8'h00},
        '{8'h69, 8'h00, 1'b0, 8'h00},
        '{8'h64, 8'ha1, 1'b0, 8'h00},
        '{8'h60, 8'hb2, 1'b0, 8'h00},
        '{8'h68, 8'h10, 1'b0, 8'h00},
        '{8'h24, 8'h00, 1'b1, 8'ha1},
        '{8'h20, 8'h00, 1'b1, 8'hb2},
        '{8'h20, 8'h00, 1'b1, 8'hb2},
        '{8'h95, 8'h3c, 1'b0, 8'h00},
        '{8'hd5, 8'h77, 1'b0, 8'h00},
        '{8'h15, 8'h00, 1'b1, 8'h3c},
        '{8'h55, 8'h00, 1'b1, 8'h77},
        '{8'h92, 8'h3c, 1'b0, 8'h00},
        '{8'h82, 8'h00, 1'b1, 8'h07}
    };

    always #5 clk = ~clk;
    // Data and I/O space slave; the read bus shows inverted data while not acknowledged.
    always @(posedge clk)
    begin
        bus_ack <= bus_req && !bus_ack;
        if (bus_req && !bus_ack && bus_we)
            mem[idx] <= bus_wdata;
    end
    assign bus_rdata = bus_ack ? mem[idx] : ~mem[idx];

    spad_decoder uut (.clk(clk), .reset_n(reset_n), .link_clk(link_clk), .phy_init(phy_init), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_break(rx_break), .rx_error(rx_error), .tx_done(tx_done), .tx_valid(tx_valid),
        .tx_data(tx_data), .phy_transmit(phy_transmit), .link_error(link_error), .bus_req(bus_req),
        .bus_we(bus_we), .bus_io(bus_io), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack),
        .bus_rdata(bus_rdata), .programming_enabled(programming_enabled));
    spad_prog_model prog (.link_clk(link_clk), .tx_valid(tx_valid), .tx_data(tx_data), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_break(rx_break), .rx_error(rx_error), .tx_done(tx_done));

    task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, e, g);
        end
    endtask
    task automatic chkn(input string name, input int e, input int g);
        checks_done++;
        if (g != e)
        begin
            err_count++;
            $display("BAD %s expected %0d seen %0d", name, e, g);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] op, input logic [7:0] d);
        prog.pulse(2'h0, op);
        prog.pulse(2'h0, d);
        repeat (8) @(negedge link_clk);
    endtask
    task automatic rd(input logic [7:0] op, output logic [7:0] v, output int k);
        prog.pulse(2'h0, op);
        prog.recv(v, k);
        if (k >= 400)
        begin
            err_count++;
            $display("BAD answer to %h expected byte seen none", op);
            end_sim();
        end
    endtask

    initial
    begin
        {clk, link_clk, reset_n, bus_ack, err_count, checks_done} = '0;
        #7;
        forever #32 link_clk = ~link_clk;
    end
    initial
    begin
        phy_init = 1'b1;
        repeat (10) @(negedge clk);
        reset_n = 1'b1;
        repeat (3) @(negedge link_clk);
        phy_init = 1'b0;
        repeat (4) @(negedge link_clk);
        chk8("enable after reset", 8'h00, {7'h0, programming_enabled});
        rd(8'h82, b, n);
        chk8("guard reset", 8'h00, b);
        for (int i = 0; i < 18; i++)
            if (rows[i].rd)
            begin
                rd(rows[i].op, b, n);
                chk8("row read", rows[i].exp, b);
            end
            else
                wr(rows[i].op, rows[i].d);
        for (int g = 0; g < 8; g++)
        begin
            wr(8'hc2, 8'(g));
            rd(8'h82, b, n);
            chkn("turnaround cycles", (g == 7 ? 0 : 128 >> g) + 2, n);
        end
        for (int k = 0; k < 2; k++)
        begin
            prog.pulse(2'h0, 8'he0);
            for (int j = 7; j >= 0; j--)
                prog.pulse(2'h0, act_key[j*8 +: 8] ^ {7'h0, k == 0});
            b = 8'h00;
            for (int p = 0; p < 6 && b[1] !== 1'b1; p++)
                rd(8'h80, b, n);
            chk8("status after key", {6'h0, k[0], 1'b0}, b & 8'h02);
            chk8("enable port", {7'h0, k[0]}, {7'h0, programming_enabled});
        end
        wr(8'hc0, 8'h00);
        rd(8'h80, b, n);
        chk8("status cleared", 8'h00, b & 8'h02);
        chk8("enable port cleared", 8'h00, {7'h0, programming_enabled});
        prog.pulse(2'h0, 8'he0);
        prog.pulse(2'h0, 8'h12);
        prog.pulse(2'h2, 8'h00);
        prog.pulse(2'h0, 8'h8f);
        chk8("error state", 8'h01, {7'h0, link_error});
        prog.pulse(2'h1, 8'h00);
        chk8("error cleared", 8'h00, {7'h0, link_error});
        prog.pulse(2'h1, 8'h00);
        prog.pulse(2'h1, 8'h00);
        chk8("two breaks", 8'h00, {7'h0, link_error});
        rd(8'h80, b, n);
        chk8("status after abort", 8'h00, b & 8'h02);
        end_sim();
    end
endmodule
